// >>> logic/tlf_notify.sv
// limit checking and fault notification with avalon register slave
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "tlf_map.svh"

// What this block does
// - open-drain low notify, interrupt or comparator
// - interrupt: high, low or fault asserts
// - hold while violation, then until cleared
// - suppress bit releases pin until cleared
// - status updates even while suppressed
// - pin shareable wired-or alert line
// - comparator: only high limits assert
// - comparator: release below high minus hysteresis
// - comparator status follows pin, auto clears
// - comparator ignores suppress, honours channel mask
// - beta compensation on channel one only
// - series resistance corrected up to 100 ohms
// - six-bit ideality per external channel
// - diode fault checked each external measurement
// - faulted channel reads zero, no low check
// - anode short reads zero, sets low
// - cathode ground short not flagged
// - separate consecutive counters for both pins
// - channel one digital filter, two levels
// - overtemp pin unmaskable with hysteresis
// - standby skips updates and limit checks
module tlf_notify #(
	parameter int CH_N  = `TLF_CH_N,
	parameter int CNT_W = `TLF_CNT_W
) (
	// clock and reset
	input  wire logic                   clk_sys_i,
	input  wire logic                   nrst_i,
	// avalon-mm slave
	input  wire logic [`TLF_ADDR_W-1:0] avs_address_i,
	input  wire logic                   avs_read_i,
	input  wire logic                   avs_write_i,
	input  wire logic [31:0]            avs_writedata_i,
	input  wire logic [3:0]             avs_byteenable_i,
	output logic [31:0]                 avs_readdata_o,
	output logic                        avs_waitrequest_o,
	// conversion front end, channel 0 internal, others external
	input  wire logic                   conv_done_i,
	input  wire logic [3:0]             conv_ch_i,
	input  wire logic [10:0]            conv_temp_i,
	input  wire logic                   diode_open_i,
	input  wire logic                   diode_vdd_short_i,
	input  wire logic                   diode_cathode_pin_gnd_i,
	input  wire logic                   diode_is_cpu_i,
	// front end settings
	output logic                        beta_comp_en_o,
	output logic [6*(CH_N-1)-1:0]       ideality_o,
	output logic                        series_resistance_correction_o,
	output logic [1:0]                  filter_level_o,
	// pins, open-drain, enable high pulls low
	output logic                        alert_n_o,
	output logic                        alert_n_oe_o,
	output logic                        therm_n_o,
	output logic                        therm_n_oe_o
);
	import tlf_pkg::*;

	typedef struct packed {
		tlf_bus_t             bus;
		logic [31:0]          rdata;
		logic [7:0]           cfg;
		logic [CH_N-1:0]      st_hi;
		logic [CH_N-1:0]      st_lo;
		logic [CH_N-1:0]      st_flt;
		logic [CH_N-1:0]      st_thm;
		logic [CH_N-1:0]      chmask;
		logic [7:0]           consec;
		logic [7:0]           hyst;
		tlf_filt_t            filt;
		logic [CH_N*8-1:0]    hilim;
		logic [CH_N*8-1:0]    lolim;
		logic [CH_N*8-1:0]    thlim;
		logic [(CH_N-1)*6-1:0] ideal;
		logic [CH_N*11-1:0]   temp;
		logic [10:0]          filt_acc;
		logic [CH_N-1:0]      hi_act;   // live high-limit violation
		logic [CH_N-1:0]      lo_act;   // live low violation
		logic [CH_N-1:0]      flt_act;  // live diode fault
		logic [CH_N-1:0]      comp_hold; // comparator assert per channel
		logic [CH_N-1:0]      th_hold;  // overtemp assert per channel
		logic                 alert;
		logic                 therm;
		logic                 beta;
	} tlf_st_t;

	tlf_st_t s;      // registered state
	tlf_st_t next_s; // next state

	// per-channel measurement decode
	logic [CH_N-1:0] meas;       // a result for this channel now
	logic [CH_N-1:0] al_bad;     // alert counter input
	logic [CH_N-1:0] th_bad;     // overtemp counter input
	logic [CH_N-1:0] al_trip;    // alert counter reached
	logic [CH_N-1:0] th_trip;    // overtemp counter reached
	logic            fault;      // diode fault on this result
	logic            anode_low;  // anode short gives zero reading
	logic [10:0]     t_eff;      // reported temperature
	logic [7:0]      t_int;      // integer part compared to limits
	logic            run;        // active conversion mode

	assign run = s.cfg[`TLF_CFG_RUN];
	// standby discards results entirely
	assign fault = diode_open_i | diode_vdd_short_i;
	assign anode_low = (conv_temp_i == `TLF_FAULT_TEMP);
	// cathode ground short has no input path to status at all
	assign t_int = t_eff[10:3];

	// result path: fault forces zero, channel one may be filtered
	always_comb begin
		t_eff = conv_temp_i;
		if (conv_ch_i != 4'h0 && fault) begin
			t_eff = `TLF_FAULT_TEMP;
		end else if (conv_ch_i == 4'h1 && s.filt != TLF_FILT_OFF) begin
			// level one averages two, level two weights history three to one
			if (s.filt == TLF_FILT_L1) begin
				t_eff = 11'((12'(s.filt_acc) + 12'(conv_temp_i)) >> 1);
			end else begin
				t_eff = 11'((13'(s.filt_acc) * 13'd3 + 13'(conv_temp_i)) >> 2);
			end
		end
	end

	// counters for each channel, separate for each pin
	genvar g;
	generate
		for (g = 0; g < CH_N; g++) begin : g_ch
			logic hi_v;
			logic lo_v;
			logic flt_v;
			logic th_v;
			assign meas[g]  = run && conv_done_i && (conv_ch_i == 4'(g));
			assign flt_v    = (g != 0) && fault;
			assign hi_v     = !flt_v && (t_int >= s.hilim[g*8 +: 8]);
			// fault skips low check; zero reading still trips it
			assign lo_v     = !flt_v && ((t_int < s.lolim[g*8 +: 8]) ||
				((g != 0) && anode_low));
			assign th_v     = !flt_v && (t_int >= s.thlim[g*8 +: 8]);
			assign al_bad[g] = hi_v | lo_v | flt_v;
			assign th_bad[g] = th_v;
			tlf_consec #(.CNT_W(CNT_W)) u_al (
				.clk_sys_i (clk_sys_i),
				.nrst_i    (nrst_i),
				.meas_i    (meas[g]),
				.bad_i     (al_bad[g]),
				.limit_i   (s.consec[CNT_W-1:0]),
				.trip_o    (al_trip[g])
			);
			tlf_consec #(.CNT_W(CNT_W)) u_th (
				.clk_sys_i (clk_sys_i),
				.nrst_i    (nrst_i),
				.meas_i    (meas[g]),
				.bad_i     (th_bad[g]),
				.limit_i   (s.consec[7:4]),
				.trip_o    (th_trip[g])
			);
		end
	endgenerate

	// main next-state logic: measurement, status, pins and register bus
	always_comb begin
		logic [7:0] rel;
		logic       acc;
		logic       rd_stat;
		logic [31:0] rd;
		rel = '0;
		acc = 1'b0;
		rd_stat = 1'b0;
		rd = '0;
		next_s = s;

		// record each result and its live violations
		for (int c = 0; c < CH_N; c++) begin
			if (meas[c]) begin
				next_s.temp[c*11 +: 11] = t_eff;
				next_s.hi_act[c] = (t_int >= s.hilim[c*8 +: 8]) && !(c != 0 && fault);
				next_s.lo_act[c] = al_bad[c] && !next_s.hi_act[c] && !(c != 0 && fault);
				next_s.flt_act[c] = (c != 0) && fault;
				if (c == 1) begin
					next_s.filt_acc = t_eff;
					next_s.beta = diode_is_cpu_i;
				end
			end
		end

		// comparator and overtemp release below limit minus hysteresis
		for (int c = 0; c < CH_N; c++) begin
			rel = (s.hilim[c*8 +: 8] > s.hyst) ? s.hilim[c*8 +: 8] - s.hyst : 8'h00;
			if (al_trip[c] && next_s.hi_act[c] && !s.chmask[c]) begin
				next_s.comp_hold[c] = 1'b1;
			end else if (meas[c] && t_int < rel) begin
				next_s.comp_hold[c] = 1'b0;
			end
			rel = (s.thlim[c*8 +: 8] > s.hyst) ? s.thlim[c*8 +: 8] - s.hyst : 8'h00;
			if (th_trip[c]) begin
				next_s.th_hold[c] = 1'b1;
			end else if (meas[c] && t_int < rel) begin
				next_s.th_hold[c] = 1'b0;
			end
		end

		// bus access, one cycle of wait then answer
		unique case (s.bus)
			TLF_BUS_IDLE: begin
				if (avs_read_i || avs_write_i) begin
					next_s.bus = TLF_BUS_ACK;
				end
			end
			TLF_BUS_ACK: begin
				next_s.bus = TLF_BUS_IDLE;
				acc = 1'b1;
			end
		endcase

		if (acc && avs_write_i && avs_byteenable_i[0]) begin
			unique case (avs_address_i) inside
				`TLF_REG_CFG:    next_s.cfg = avs_writedata_i[7:0];
				`TLF_REG_CHMASK: next_s.chmask = avs_writedata_i[CH_N-1:0];
				`TLF_REG_CONSEC: next_s.consec = avs_writedata_i[7:0];
				`TLF_REG_HYST:   next_s.hyst = avs_writedata_i[7:0];
				`TLF_REG_FILTER: next_s.filt = tlf_filt_t'(avs_writedata_i[1:0]);
				default: begin
					for (int c = 0; c < CH_N; c++) begin
						if (avs_address_i == `TLF_REG_HILIM + 6'(c))
							next_s.hilim[c*8 +: 8] = avs_writedata_i[7:0];
						if (avs_address_i == `TLF_REG_LOLIM + 6'(c))
							next_s.lolim[c*8 +: 8] = avs_writedata_i[7:0];
						if (avs_address_i == `TLF_REG_THLIM + 6'(c))
							next_s.thlim[c*8 +: 8] = avs_writedata_i[7:0];
						if (c > 0 && avs_address_i == `TLF_REG_IDEAL + 6'(c))
							next_s.ideal[(c-1)*6 +: 6] = avs_writedata_i[5:0];
					end
				end
			endcase
		end

		// read data mux; unmapped reads as zero
		// captured when the request is taken so it stands in the answer cycle
		if (s.bus == TLF_BUS_IDLE && avs_read_i) begin
			unique case (avs_address_i) inside
				`TLF_REG_CFG:      rd = 32'(s.cfg);
				`TLF_REG_STAT_HI:  rd = 32'(s.st_hi);
				`TLF_REG_STAT_LO:  rd = 32'(s.st_lo);
				`TLF_REG_STAT_FLT: rd = 32'(s.st_flt);
				`TLF_REG_STAT_THM: rd = 32'(s.st_thm);
				`TLF_REG_CHMASK:   rd = 32'(s.chmask);
				`TLF_REG_CONSEC:   rd = 32'(s.consec);
				`TLF_REG_HYST:     rd = 32'(s.hyst);
				`TLF_REG_FILTER:   rd = 32'(s.filt);
				`TLF_REG_PINS:     rd = {29'h0, s.beta, s.therm, s.alert};
				default: begin
					for (int c = 0; c < CH_N; c++) begin
						if (avs_address_i == `TLF_REG_HILIM + 6'(c))
							rd = 32'(s.hilim[c*8 +: 8]);
						if (avs_address_i == `TLF_REG_LOLIM + 6'(c))
							rd = 32'(s.lolim[c*8 +: 8]);
						if (avs_address_i == `TLF_REG_THLIM + 6'(c))
							rd = 32'(s.thlim[c*8 +: 8]);
						if (c > 0 && avs_address_i == `TLF_REG_IDEAL + 6'(c))
							rd = 32'(s.ideal[(c-1)*6 +: 6]);
						if (avs_address_i == `TLF_REG_TEMP + 6'(c))
							rd = 32'(s.temp[c*11 +: 11]);
					end
				end
			endcase
		end
		// status read-clear acts at the edge that ends the answer cycle
		if (acc && avs_read_i) begin
			rd_stat = (avs_address_i >= `TLF_REG_STAT_HI) &&
				(avs_address_i <= `TLF_REG_STAT_FLT);
		end
		if (s.bus == TLF_BUS_IDLE && avs_read_i) begin
			next_s.rdata = rd;
		end

		// status: interrupt read clears where no violation remains, comparator read clears low and fault outright; sets win
		if (s.cfg[`TLF_CFG_COMP]) begin
			next_s.st_hi = next_s.comp_hold;
			if (rd_stat) begin
				next_s.st_lo = '0;
				next_s.st_flt = '0;
			end
		end else if (rd_stat) begin
			next_s.st_hi = s.st_hi & s.hi_act;
			next_s.st_lo = s.st_lo & s.lo_act;
			next_s.st_flt = s.st_flt & s.flt_act;
		end
		for (int c = 0; c < CH_N; c++) begin
			if (meas[c] && al_trip[c] && !s.cfg[`TLF_CFG_COMP]) begin
				// still set while suppressed
				if (next_s.hi_act[c]) next_s.st_hi[c] = 1'b1;
				if (next_s.lo_act[c]) next_s.st_lo[c] = 1'b1;
			end
			if (meas[c] && c != 0 && fault) next_s.st_flt[c] = 1'b1;
		end
		next_s.st_thm = next_s.th_hold;

		// pin drive per mode
		if (next_s.cfg[`TLF_CFG_COMP]) begin
			next_s.alert = |next_s.comp_hold;
		end else begin
			// live violation or uncleared status holds the pin
			next_s.alert = !next_s.cfg[`TLF_CFG_SUPPRESS] &&
				(|(next_s.st_hi | next_s.st_lo | next_s.st_flt));
		end
		next_s.therm = |next_s.th_hold;
	end

	// state register with reset values
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			s <= '0;
			s.hilim <= {CH_N{`TLF_HILIM_RST}};
			s.lolim <= {CH_N{`TLF_LOLIM_RST}};
			s.thlim <= {CH_N{`TLF_THLIM_RST}};
			s.hyst <= `TLF_HYST_RST;
			s.consec <= `TLF_CONSEC_RST;
			s.ideal <= {(CH_N-1){`TLF_IDEAL_RST}};
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from state; pin level is low, enable pulls
	assign avs_readdata_o = s.rdata;
	assign avs_waitrequest_o = (s.bus != TLF_BUS_ACK);
	assign alert_n_o = 1'b0;
	assign alert_n_oe_o = s.alert;
	assign therm_n_o = 1'b0;
	assign therm_n_oe_o = s.therm;
	assign beta_comp_en_o = s.beta;
	assign ideality_o = s.ideal;
	// resistance correction always on, range limit is analog
	assign series_resistance_correction_o = 1'b1;
	assign filter_level_o = s.filt;
endmodule

// >>> logic/tlf_map.svh
// offsets, field positions, reset values and counts for the limit and fault block
`ifndef TLF_MAP_SVH
`define TLF_MAP_SVH
`define TLF_CH_N          4
`define TLF_ADDR_W        6
`define TLF_REG_CFG       6'h00
`define TLF_REG_STAT_HI   6'h01
`define TLF_REG_STAT_LO   6'h02
`define TLF_REG_STAT_FLT  6'h03
`define TLF_REG_STAT_THM  6'h04
`define TLF_REG_CHMASK    6'h05
`define TLF_REG_CONSEC    6'h06
`define TLF_REG_HYST      6'h07
`define TLF_REG_FILTER    6'h08
`define TLF_REG_PINS      6'h09
`define TLF_REG_HILIM     6'h10
`define TLF_REG_LOLIM     6'h14
`define TLF_REG_THLIM     6'h18
`define TLF_REG_IDEAL     6'h1c
`define TLF_REG_TEMP      6'h20
`define TLF_CFG_SUPPRESS  0
`define TLF_CFG_COMP      1
`define TLF_CFG_RUN       2
`define TLF_HILIM_RST     8'h55
`define TLF_LOLIM_RST     8'h00
`define TLF_THLIM_RST     8'h55
`define TLF_HYST_RST      8'h0a
`define TLF_IDEAL_RST     6'h12
`define TLF_CONSEC_RST    8'h00
`define TLF_CNT_W         4
`define TLF_FAULT_TEMP    11'h000
`endif

// >>> logic/tlf_pkg.sv
// types for the limit and fault notification block
package tlf_pkg;
	typedef enum logic [1:0] {
		TLF_FILT_OFF = 2'b00,
		TLF_FILT_L1  = 2'b01,
		TLF_FILT_L2  = 2'b10
	} tlf_filt_t;
	typedef enum logic [1:0] {
		TLF_BUS_IDLE = 2'b00,
		TLF_BUS_ACK  = 2'b01
	} tlf_bus_t;
endpackage

// >>> logic/tlf_consec.sv
// per-channel consecutive violation counter
`timescale 1ns/1ps
module tlf_consec #(
	parameter int CNT_W = 4
) (
	// clock and reset
	input  wire logic             clk_sys_i,
	input  wire logic             nrst_i,
	// measurement event
	input  wire logic             meas_i,   // one result this cycle
	input  wire logic             bad_i,    // result out of limit or faulted
	input  wire logic [CNT_W-1:0] limit_i,  // count needed, zero acts as one
	// result
	output logic                  trip_o    // this bad result reaches the count
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} tlf_cs_t;
	tlf_cs_t s;       // registered state
	tlf_cs_t next_s;  // next state
	logic [CNT_W-1:0] need;

	// count consecutive bad results; saturate at the programmed figure
	always_comb begin
		next_s = s;
		need = (limit_i == '0) ? CNT_W'(1) : limit_i;
		if (meas_i) begin
			if (!bad_i) begin
				next_s.cnt = '0;
			end else if (s.cnt < need) begin
				next_s.cnt = s.cnt + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// judged on the result itself, so a count of n trips on the nth bad result
	assign trip_o = meas_i && bad_i && (s.cnt >= need - CNT_W'(1));
endmodule

// >>> verif/tlf_host.sv
// avalon-mm host model standing in for the bus controller
`timescale 1ns/1ps
module tlf_host (
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	// request from the bench
	input  wire logic        go_i,
	input  wire logic        wr_i,
	input  wire logic [5:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	output logic             done_o,
	output logic [31:0]      rdata_o,
	// avalon-mm master side
	output logic             read_o,
	output logic             write_o,
	output logic [5:0]       address_o,
	output logic [31:0]      writedata_o,
	input  wire logic        waitrequest_i,
	input  wire logic [31:0] readdata_i
);
	// known levels from time zero
	initial begin
		read_o = 1'b0;
		write_o = 1'b0;
		done_o = 1'b0;
		address_o = 6'h00;
		writedata_o = 32'h0;
	end
	// hold each request until waitrequest is sampled low
	always @(posedge clk_sys_i) begin
		done_o <= 1'b0;
		if (!nrst_i) begin
			read_o <= 1'b0;
			write_o <= 1'b0;
		end else if ((read_o || write_o) && !waitrequest_i) begin
			// released lines flip so stale values are never trusted
			read_o <= 1'b0;
			write_o <= 1'b0;
			address_o <= ~address_o;
			writedata_o <= ~writedata_o;
			rdata_o <= readdata_i;
			done_o <= 1'b1;
		end else if (go_i && !read_o && !write_o) begin
			read_o <= !wr_i;
			write_o <= wr_i;
			address_o <= addr_i;
			writedata_o <= wdata_i;
		end
	end
endmodule

// >>> verif/tlf_notify_assertions.sv
// bus and pin checks for the limit and fault block
`timescale 1ns/1ps
module tlf_chk #(
	parameter int CH_N = 4
) (
	// clock and reset
	input  wire logic                  clk_sys_i,
	input  wire logic                  nrst_i,
	// register bus
	input  wire logic [5:0]            avs_address_i,
	input  wire logic                  avs_read_i,
	input  wire logic                  avs_write_i,
	input  wire logic [31:0]           avs_readdata_o,
	input  wire logic                  avs_waitrequest_o,
	// front end
	input  wire logic                  conv_done_i,
	input  wire logic [3:0]            conv_ch_i,
	input  wire logic                  beta_comp_en_o,
	input  wire logic [6*(CH_N-1)-1:0] ideality_o,
	input  wire logic                  series_resistance_correction_o,
	input  wire logic [1:0]            filter_level_o,
	// pins
	input  wire logic                  alert_n_o,
	input  wire logic                  alert_n_oe_o,
	input  wire logic                  therm_n_o,
	input  wire logic                  therm_n_oe_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	// recent causes: a pin may only move shortly after one
	logic [2:0] hc;
	logic [2:0] hr;
	always_ff @(posedge clk_sys_i) begin
		hc <= {hc[1:0], conv_done_i || avs_write_i};
		hr <= {hr[1:0], conv_done_i || avs_write_i || avs_read_i};
	end
	// one access: taken while idle, answered for one cycle
	sequence s_req; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
	sequence s_ack; !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence
	property p_ack; s_req |=> s_ack; endproperty
	a_ack: assert property (p_ack) else $error("bus answer wrong");
	property p_unmap;
		avs_read_i && avs_address_i == 6'h3f && !avs_waitrequest_o |-> avs_readdata_o == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_open; alert_n_o == 1'b0 && therm_n_o == 1'b0; endproperty
	a_open: assert property (p_open) else $error("pin drives high");
	property p_src; series_resistance_correction_o; endproperty
	a_src: assert property (p_src) else $error("correction off");
	property p_arise; $rose(alert_n_oe_o) |-> |hc; endproperty
	a_arise: assert property (p_arise) else $error("alert rose uncaused");
	property p_trise; $rose(therm_n_oe_o) |-> |hc; endproperty
	a_trise: assert property (p_trise) else $error("therm rose uncaused");
	property p_fall; $fell(alert_n_oe_o) |-> |hr; endproperty
	a_fall: assert property (p_fall) else $error("alert fell uncaused");
	property p_beta;
		$changed(beta_comp_en_o) |->
			$past(conv_done_i && conv_ch_i == 4'h1) || $past(conv_done_i && conv_ch_i == 4'h1, 2);
	endproperty
	a_beta: assert property (p_beta) else $error("beta moved off channel one");
	property p_ideal; $changed(ideality_o) |-> $past(avs_write_i); endproperty
	a_ideal: assert property (p_ideal) else $error("ideality moved alone");
	property p_filt; $changed(filter_level_o) |-> $past(avs_write_i); endproperty
	a_filt: assert property (p_filt) else $error("filter moved alone");
endmodule
bind tlf_notify tlf_chk #(.CH_N(CH_N)) u_chk (.clk_sys_i, .nrst_i, .avs_address_i,
	.avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .conv_done_i,
	.conv_ch_i, .beta_comp_en_o, .ideality_o, .series_resistance_correction_o,
	.filter_level_o, .alert_n_o, .alert_n_oe_o, .therm_n_o, .therm_n_oe_o);

// >>> verif/tlf_notify_tb.sv
// self-checking bench for the limit and fault block
`timescale 1ns/1ps
module tlf_notify_tb;
	import tlf_pkg::*;
	typedef struct packed {logic [5:0] a; logic [31:0] e;} tlf_row_t;
	// reset values, unmapped word last
	tlf_row_t rows [8] = '{'{6'h10, 32'h55}, '{6'h13, 32'h55}, '{6'h14, 32'h0},
		'{6'h18, 32'h55}, '{6'h07, 32'h0a}, '{6'h1e, 32'h12}, '{6'h00, 32'h0}, '{6'h3f, 32'h0}};
	logic clk_sys_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [5:0] avs_address_i;
	logic avs_read_i;
	logic avs_write_i;
	logic [31:0] avs_writedata_i;
	logic [3:0] avs_byteenable_i = 4'hf;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic conv_done_i = 1'b0;
	logic [3:0] conv_ch_i = 4'h0;
	logic [10:0] conv_temp_i = 11'h0;
	logic diode_open_i = 1'b0;
	logic diode_vdd_short_i = 1'b0;
	logic diode_cathode_pin_gnd_i = 1'b0;
	logic diode_is_cpu_i = 1'b0;
	logic beta_comp_en_o;
	logic [17:0] ideality_o;
	logic series_resistance_correction_o;
	logic [1:0] filter_level_o;
	logic alert_n_o;
	logic alert_n_oe_o;
	logic therm_n_o;
	logic therm_n_oe_o;
	logic go = 1'b0;
	logic wr = 1'b0;
	logic [5:0] adr = 6'h0;
	logic [31:0] wd = 32'h0;
	logic done;
	logic [31:0] rdat;
	int err_total = 0;
	int n_checks = 0;
	// wired lines with pull-ups, shareable by other devices
	wire aw = alert_n_oe_o ? alert_n_o : 1'b1;
	wire tw = therm_n_oe_o ? therm_n_o : 1'b1;
	always #50 clk_sys_i = ~clk_sys_i;
	tlf_notify #(.CH_N(4), .CNT_W(4)) i_dut (.clk_sys_i, .nrst_i, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
		.conv_done_i, .conv_ch_i, .conv_temp_i, .diode_open_i, .diode_vdd_short_i,
		.diode_cathode_pin_gnd_i, .diode_is_cpu_i, .beta_comp_en_o, .ideality_o,
		.series_resistance_correction_o, .filter_level_o, .alert_n_o, .alert_n_oe_o,
		.therm_n_o, .therm_n_oe_o);
	tlf_host u_host (.clk_sys_i, .nrst_i, .go_i(go), .wr_i(wr), .addr_i(adr), .wdata_i(wd),
		.done_o(done), .rdata_o(rdat), .read_o(avs_read_i), .write_o(avs_write_i),
		.address_o(avs_address_i), .writedata_o(avs_writedata_i),
		.waitrequest_i(avs_waitrequest_o), .readdata_i(avs_readdata_o));
	// compare and count
	task automatic c(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			err_total++;
			$display("mismatch at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	// one bus access through the host, then let pins settle
	task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		go <= 1'b1;
		wr <= w;
		adr <= a;
		wd <= d;
		@(posedge clk_sys_i);
		go <= 1'b0;
		for (int i = 0; i < 20 && done !== 1'b1; i++) @(posedge clk_sys_i);
		if (done !== 1'b1) err_total++;
		repeat (3) @(posedge clk_sys_i);
	endtask
	task automatic w(input logic [5:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask
	task automatic r(input logic [5:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		c(rdat, e);
	endtask
	// n results on one channel; f is cpu, cathode short, supply short, open
	task automatic m(input logic [3:0] ch, input logic [7:0] t, input logic [3:0] f, input int n);
		repeat (n) begin
			@(posedge clk_sys_i);
			conv_done_i <= 1'b1;
			conv_ch_i <= ch;
			conv_temp_i <= {t, 3'h0};
			{diode_is_cpu_i, diode_cathode_pin_gnd_i, diode_vdd_short_i, diode_open_i} <= f;
			@(posedge clk_sys_i);
			conv_done_i <= 1'b0;
			conv_temp_i <= ~conv_temp_i;
			{diode_is_cpu_i, diode_cathode_pin_gnd_i, diode_vdd_short_i, diode_open_i} <= 4'h0;
			repeat (3) @(posedge clk_sys_i);
		end
	endtask
	// verdict, the single way out
	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// watchdog well past the expected run length
	initial begin
		#2000000;
		err_total++;
		end_of_test();
	end
	// main sequence
	initial begin
		repeat (4) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		foreach (rows[i]) r(rows[i].a, rows[i].e);
		c(series_resistance_correction_o, 1);
		w(6'h1d, 32'h2a);
		c(ideality_o[5:0], 6'h2a);
		w(6'h08, TLF_FILT_L2);
		c(filter_level_o, TLF_FILT_L2);
		w(6'h08, TLF_FILT_OFF);
		c(filter_level_o, TLF_FILT_OFF);
		m(1, 8'h60, 0, 2); // standby
		c(aw, 1);
		r(6'h01, 0);
		w(6'h00, 4);
		m(1, 8'h55, 8, 2);
		c(aw, 0);
		c(beta_comp_en_o, 1);
		r(6'h01, 2);
		c(aw, 0);
		m(1, 8'h30, 0, 1);
		c(aw, 0);
		r(6'h01, 2);
		c(aw, 1);
		r(6'h01, 0);
		// suppress while asserted, then more violations
		m(2, 8'h70, 0, 2);
		c(aw, 0);
		w(6'h00, 5);
		c(aw, 1);
		m(3, 8'h70, 0, 2);
		c(aw, 1);
		m(2, 8'h30, 0, 1);
		m(3, 8'h30, 0, 1);
		r(6'h01, 32'hc);
		w(6'h00, 4);
		c(aw, 1);
		// open diode on channel two
		m(2, 8'h40, 1, 2);
		c(aw, 0);
		r(6'h22, 0);
		r(6'h02, 0);
		m(2, 8'h30, 0, 1);
		r(6'h03, 4);
		c(aw, 1);
		// supply short on channel three
		m(3, 8'h40, 2, 2);
		c(aw, 0);
		m(3, 8'h30, 0, 1);
		r(6'h03, 8);
		// anode short reads as zero
		m(3, 8'h00, 0, 2);
		c(aw, 0);
		r(6'h23, 0);
		m(3, 8'h30, 0, 1);
		r(6'h02, 8);
		m(1, 8'h30, 4, 2);
		c(aw, 1);
		r(6'h03, 0);
		// level one filter: mean of previous and new result
		w(6'h08, TLF_FILT_L1);
		m(1, 8'h20, 0, 1);
		r(6'h21, 32'h140);
		w(6'h08, TLF_FILT_OFF);
		// consecutive count of three, broken by a good result
		w(6'h06, 3);
		m(1, 8'h60, 0, 2);
		m(1, 8'h30, 0, 1);
		m(1, 8'h60, 0, 2);
		c(aw, 1);
		m(1, 8'h60, 0, 1);
		c(aw, 0);
		m(1, 8'h30, 0, 1);
		r(6'h01, 2);
		w(6'h06, 0);
		// overtemperature with hysteresis
		m(0, 8'h56, 0, 2);
		c(tw, 0);
		m(0, 8'h50, 0, 1);
		c(tw, 0);
		m(0, 8'h40, 0, 1);
		c(tw, 1);
		r(6'h04, 0);
		r(6'h01, 1);
		// comparator mode
		w(6'h00, 6);
		m(1, 8'h60, 0, 2);
		c(aw, 0);
		r(6'h01, 2);
		c(aw, 0);
		m(1, 8'h50, 0, 1);
		c(aw, 0);
		m(1, 8'h40, 0, 1);
		c(aw, 1);
		r(6'h01, 0);
		w(6'h15, 32'h20);
		m(1, 8'h10, 0, 2);
		c(aw, 1);
		w(6'h00, 7);
		m(1, 8'h60, 0, 2);
		c(aw, 0);
		m(1, 8'h40, 0, 1);
		w(6'h05, 2);
		m(1, 8'h60, 0, 2);
		c(aw, 1);
		// second reset in mid-run
		@(posedge clk_sys_i);
		nrst_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		r(6'h00, 0);
		c(ideality_o[5:0], 6'h12);
		end_of_test();
	end
endmodule
